/* verilog/eiec_pkg.sv */
// Constants and register map of the edge interrupt and event controller.
// How it works
// (RULE1) 32 edge lines, each raising interrupt, event and wake-up requests.
// (RULE2) Rising, falling or both edges selected per line by software.
// (RULE3) Per-line masks gate forwarding; one line's mask never affects another.
// (RULE4) Pending register holds one bit per line for outstanding requests.
// (RULE5) Pin pulses shorter than a clock period are caught asynchronously.
// (RULE6) Any of 88 pins routes to each of 16 external lines.
// (RULE7) Pending bit stays set until software writes one to it.
package eiec_pkg;

  // ==========================================================================
  // Sizes
  localparam int NUM_LINES = 32;
  localparam int NUM_EXT = 16;
  localparam int NUM_INT = NUM_LINES - NUM_EXT;
  localparam int NUM_PINS = 88;
  localparam int SEL_W = 8;
  localparam int SEL_PER_REG = 4;
  localparam int NUM_SRC_REGS = NUM_EXT / SEL_PER_REG;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;

  // ==========================================================================
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_EVENT_MASK = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_RISE_SEL = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_FALL_SEL = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_PENDING = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_SRC0 = 8'h18;
  localparam logic [ADDR_W-1:0] REG_STRIDE = 8'h04;

  // ==========================================================================
  // Reset values and responses
  localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
  localparam logic [SEL_W*NUM_EXT-1:0] RST_SRC = '0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : eiec_pkg

/* verilog/edge_capture_line.sv */
// Asynchronous edge capture of one line with resynchronisation.
`timescale 1ns/1ps
module edge_capture_line (
  input wire logic clock,
  input wire logic rstn,
  input wire logic line_in,
  output logic rise_seen,
  output logic fall_seen
);

  // ==========================================================================
  // Capture on the line itself
  // The line clocks its own toggle flops, so a pulse far shorter than the
  // system clock still flips both toggles and cannot be missed.
  logic rise_tog;
  logic fall_tog;

  always_ff @(posedge line_in or negedge rstn)
  begin
    if (!rstn)
      rise_tog <= 1'b0;
    else
      rise_tog <= ~rise_tog; // [RULE5]
  end

  always_ff @(negedge line_in or negedge rstn)
  begin
    if (!rstn)
      fall_tog <= 1'b0;
    else
      fall_tog <= ~fall_tog; // [RULE5]
  end

  // ==========================================================================
  // Synchronise toggles and turn changes into pulses
  logic [1:0] rise_meta;
  logic [1:0] fall_meta;
  logic rise_last;
  logic fall_last;
  logic next_rise_seen;
  logic next_fall_seen;

  always_comb
  begin
    next_rise_seen = rise_meta[1] ^ rise_last;
    next_fall_seen = fall_meta[1] ^ fall_last;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rise_meta <= 2'h0;
      fall_meta <= 2'h0;
      rise_last <= 1'b0;
      fall_last <= 1'b0;
      rise_seen <= 1'b0;
      fall_seen <= 1'b0;
    end
    else
    begin
      rise_meta <= {rise_meta[0], rise_tog};
      fall_meta <= {fall_meta[0], fall_tog};
      rise_last <= rise_meta[1];
      fall_last <= fall_meta[1];
      rise_seen <= next_rise_seen;
      fall_seen <= next_fall_seen;
    end
  end

  // ==========================================================================
  // Checks
  sequence rise_changed_s;
    rise_meta[1] != rise_last;
  endsequence

  rise_pulse_a: assert property ( // [RULE5]
    @(posedge clock) disable iff (!rstn)
    rise_changed_s |=> rise_seen
      ##1 (!rise_seen || $past(rise_meta[1]) != $past(rise_last)))
    else $error("Synchronised rising toggle did not give one pulse.");

  fall_pulse_a: assert property ( // [RULE5]
    @(posedge clock) disable iff (!rstn)
    fall_seen |-> $past(fall_meta[1]) != $past(fall_last))
    else $error("Falling pulse without a synchronised toggle change.");

endmodule : edge_capture_line

/* verilog/edge_interrupt_event_controller.sv */
// Edge interrupt and event controller with AXI4-Lite register access.
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
module edge_interrupt_event_controller (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [eiec_pkg::NUM_PINS-1:0] gpio_pins,
  input wire logic [eiec_pkg::NUM_INT-1:0] internal_lines,
  input wire logic awvalid,
  output logic awready,
  input wire logic [eiec_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [eiec_pkg::DATA_W-1:0] wdata,
  input wire logic [eiec_pkg::STRB_W-1:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [eiec_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [eiec_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic irq,
  output logic [eiec_pkg::NUM_LINES-1:0] line_irq,
  output logic [eiec_pkg::NUM_LINES-1:0] line_event,
  output logic wakeup
);

  localparam int NL = eiec_pkg::NUM_LINES;
  localparam int DW = eiec_pkg::DATA_W;
  localparam int SW = eiec_pkg::SEL_W;
  localparam int SRC_W = SW * eiec_pkg::NUM_EXT;

  function automatic logic [DW-1:0] lane_mask(
    input logic [eiec_pkg::STRB_W-1:0] strb);
    logic [DW-1:0] m;
    m = '0;
    for (int b = 0; b < eiec_pkg::STRB_W; b++)
      m[8*b +: 8] = {8{strb[b]}};
    return m;
  endfunction : lane_mask

  // ==========================================================================
  // Registers
  logic [NL-1:0] irq_mask, event_mask, rise_select, fall_select, pending;
  logic [SRC_W-1:0] src_sel;
  logic aw_held, w_held;
  logic [eiec_pkg::ADDR_W-1:0] aw_addr;
  logic [DW-1:0] w_data;
  logic [eiec_pkg::STRB_W-1:0] w_strb;

  // ==========================================================================
  // Pin routing and edge capture
  // Changing a source select can itself look like an edge on that line;
  // software should mask the line while rerouting it.
  logic [NL-1:0] line_level, rise_seen, fall_seen;

  always_comb
  begin
    line_level = '0;
    for (int i = 0; i < eiec_pkg::NUM_EXT; i++)
      for (int p = 0; p < eiec_pkg::NUM_PINS; p++)
        if (src_sel[SW*i +: SW] == SW'(p))
          line_level[i] = gpio_pins[p]; // [RULE6]
    line_level[NL-1:eiec_pkg::NUM_EXT] = internal_lines;
  end

  for (genvar g = 0; g < NL; g++)
  begin : capture
    edge_capture_line line_capture (
      .clock(clock),
      .rstn(rstn),
      .line_in(line_level[g]),
      .rise_seen(rise_seen[g]),
      .fall_seen(fall_seen[g])
    ); // [RULE1] [RULE5]
  end

  // ==========================================================================
  // Request logic
  logic [NL-1:0] hit, set_vec;

  always_comb
  begin
    hit = (rise_seen & rise_select) | (fall_seen & fall_select); // [RULE2]
    set_vec = hit & irq_mask; // [RULE3]
  end

  // ==========================================================================
  // Bus slave and register updates
  logic do_write, pend_wr, wr_hit;
  logic next_aw_held, next_w_held, next_bvalid, next_rvalid;
  logic [eiec_pkg::ADDR_W-1:0] next_aw_addr;
  logic [eiec_pkg::STRB_W-1:0] next_w_strb;
  logic [DW-1:0] wmask, next_w_data, next_rdata;
  logic [1:0] next_bresp, next_rresp;
  logic [NL-1:0] next_irq_mask, next_event_mask, next_pending;
  logic [NL-1:0] next_rise_select, next_fall_select;
  logic [SRC_W-1:0] next_src_sel;

  always_comb
  begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid && !bready;
    next_bresp = bresp;
    next_rvalid = rvalid && !rready;
    next_rdata = rdata;
    next_rresp = rresp;
    next_irq_mask = irq_mask;
    next_event_mask = event_mask;
    next_rise_select = rise_select;
    next_fall_select = fall_select;
    next_src_sel = src_sel;
    pend_wr = 1'b0;
    wr_hit = 1'b1;
    wmask = lane_mask(w_strb);
    if (awvalid && awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready)
    begin
      next_w_held = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    do_write = aw_held && w_held && !bvalid;
    if (do_write)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      case (aw_addr)
        eiec_pkg::OFF_IRQ_MASK:
          next_irq_mask = (irq_mask & ~wmask) | (w_data & wmask);
        eiec_pkg::OFF_EVENT_MASK:
          next_event_mask = (event_mask & ~wmask) | (w_data & wmask);
        eiec_pkg::OFF_RISE_SEL:
          next_rise_select = (rise_select & ~wmask) | (w_data & wmask);
        eiec_pkg::OFF_FALL_SEL:
          next_fall_select = (fall_select & ~wmask) | (w_data & wmask);
        eiec_pkg::OFF_PENDING:
          pend_wr = 1'b1;
        default:
        begin
          wr_hit = 1'b0;
          for (int k = 0; k < eiec_pkg::NUM_SRC_REGS; k++)
            if (aw_addr == eiec_pkg::OFF_SRC0
                + eiec_pkg::ADDR_W'(k) * eiec_pkg::REG_STRIDE)
            begin
              wr_hit = 1'b1;
              next_src_sel[DW*k +: DW] = (src_sel[DW*k +: DW] & ~wmask)
                | (w_data & wmask); // [RULE6]
            end
        end
      endcase
      next_bresp = wr_hit ? eiec_pkg::RESP_OKAY : eiec_pkg::RESP_SLVERR;
    end
    // A new edge wins over a clear written in the same cycle.
    next_pending = (pending & ~({DW{pend_wr}} & w_data & wmask))
      | set_vec; // [RULE4] [RULE7]
    if (arvalid && arready)
    begin
      next_rvalid = 1'b1;
      next_rresp = eiec_pkg::RESP_OKAY;
      next_rdata = eiec_pkg::RST_WORD;
      case (araddr)
        eiec_pkg::OFF_IRQ_MASK: next_rdata = irq_mask;
        eiec_pkg::OFF_EVENT_MASK: next_rdata = event_mask;
        eiec_pkg::OFF_RISE_SEL: next_rdata = rise_select;
        eiec_pkg::OFF_FALL_SEL: next_rdata = fall_select;
        eiec_pkg::OFF_PENDING: next_rdata = pending;
        default:
        begin
          next_rresp = eiec_pkg::RESP_SLVERR;
          for (int k = 0; k < eiec_pkg::NUM_SRC_REGS; k++)
            if (araddr == eiec_pkg::OFF_SRC0
                + eiec_pkg::ADDR_W'(k) * eiec_pkg::REG_STRIDE)
            begin
              next_rresp = eiec_pkg::RESP_OKAY;
              next_rdata = src_sel[DW*k +: DW];
            end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      {aw_held, w_held} <= 2'h0;
      aw_addr <= '0;
      w_data <= eiec_pkg::RST_WORD;
      w_strb <= '0;
      {awready, wready, arready, bvalid} <= 4'h0;
      bresp <= eiec_pkg::RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= eiec_pkg::RST_WORD;
      rresp <= eiec_pkg::RESP_OKAY;
      irq_mask <= eiec_pkg::RST_WORD;
      event_mask <= eiec_pkg::RST_WORD;
      rise_select <= eiec_pkg::RST_WORD;
      fall_select <= eiec_pkg::RST_WORD;
      pending <= eiec_pkg::RST_WORD;
      src_sel <= eiec_pkg::RST_SRC;
      {irq, wakeup} <= 2'h0;
      line_irq <= '0;
      line_event <= '0;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      awready <= !next_aw_held;
      wready <= !next_w_held;
      arready <= !next_rvalid;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      irq_mask <= next_irq_mask;
      event_mask <= next_event_mask;
      rise_select <= next_rise_select;
      fall_select <= next_fall_select;
      pending <= next_pending;
      src_sel <= next_src_sel;
      irq <= |(pending & irq_mask); // [RULE3]
      line_irq <= pending & irq_mask; // [RULE1] [RULE3]
      line_event <= hit & event_mask; // [RULE1] [RULE3]
      wakeup <= |(hit & (irq_mask | event_mask)); // [RULE1]
    end
  end

  // ==========================================================================
  // Checks
  sequence both_halves_s;
    aw_held && w_held && !bvalid;
  endsequence

  pending_set_a: assert property ( // [RULE4]
    @(posedge clock) disable iff (!rstn)
    |set_vec |=> ((pending & $past(set_vec)) == $past(set_vec)))
    else $error("Selected unmasked edge did not set its pending bit.");

  pending_hold_a: assert property ( // [RULE7]
    @(posedge clock) disable iff (!rstn)
    !pend_wr |=> ((pending & $past(pending)) == $past(pending)))
    else $error("Pending bit dropped without a software clear.");

  irq_level_a: assert property ( // [RULE3]
    @(posedge clock) disable iff (!rstn)
    irq == (|line_irq))
    else $error("Interrupt output disagrees with line requests.");

  event_mask_a: assert property ( // [RULE3]
    @(posedge clock) disable iff (!rstn)
    (line_event & ~$past(event_mask)) == '0)
    else $error("Event request passed a masked line.");

  edge_select_a: assert property ( // [RULE2]
    @(posedge clock) disable iff (!rstn)
    (rise_seen[0] && !fall_seen[0] && !rise_select[0]) |-> !hit[0])
    else $error("Rising edge triggered a line not set for it.");

  wake_a: assert property ( // [RULE1]
    @(posedge clock) disable iff (!rstn)
    (|(hit & (irq_mask | event_mask))) |=> wakeup)
    else $error("Unmasked request raised no wake-up.");

  route_a: assert property ( // [RULE6]
    @(posedge clock) disable iff (!rstn)
    (src_sel[SW-1:0] >= SW'(eiec_pkg::NUM_PINS)) |-> !line_level[0])
    else $error("Out-of-range source select drove an external line.");

  write_resp_a: assert property (
    @(posedge clock) disable iff (!rstn)
    both_halves_s |=> bvalid ##0 !aw_held)
    else $error("Write with both halves did not answer next cycle.");

  bresp_hold_a: assert property (
    @(posedge clock) disable iff (!rstn)
    (bvalid && !bready) |=> (bvalid && $stable(bresp)))
    else $error("Write response dropped before acceptance.");

endmodule : edge_interrupt_event_controller

/* test/gpio_irq_partner.sv */
// Far-side model: pins that feed the controller and an event counter.
`timescale 1ns/1ps
module gpio_irq_partner (
  input wire logic clock,
  input wire logic [eiec_pkg::NUM_LINES-1:0] line_event,
  input wire logic wakeup,
  output logic [eiec_pkg::NUM_PINS-1:0] gpio_pins
);
  int event_count [eiec_pkg::NUM_LINES];
  int wake_count;

  initial
  begin
    gpio_pins = '0;
    wake_count = 0;
    foreach (event_count[i])
      event_count[i] = 0;
  end

  // Pins change on their own time, not on the clock, as real pads do.
  task automatic pulse(input int pin, input int width_ns);
    gpio_pins[pin] = 1'b1;
    #(width_ns);
    gpio_pins[pin] = 1'b0;
  endtask : pulse

  task automatic set_pin(input int pin, input logic lvl);
    gpio_pins[pin] = lvl;
  endtask : set_pin

  always @(posedge clock)
  begin
    foreach (event_count[i])
      event_count[i] += (line_event[i] === 1'b1);
    wake_count += (wakeup === 1'b1);
  end
endmodule : gpio_irq_partner

/* test/test_edge_interrupt_event_controller.sv */
// Self-checking testbench of the edge interrupt and event controller.
`timescale 1ns/1ps
module test_edge_interrupt_event_controller;
  logic clock, rstn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq, wakeup;
  logic [eiec_pkg::NUM_PINS-1:0] gpio_pins;
  logic [eiec_pkg::NUM_INT-1:0] internal_lines;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [31:0] line_irq, line_event;
  logic [1:0] bresp, rresp;
  logic [3:0] wstrb;
  int n_errors = 0;
  int n_tests = 0;

  edge_interrupt_event_controller dut_u (
    .clock(clock), .rstn(rstn), .gpio_pins(gpio_pins),
    .internal_lines(internal_lines), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .awprot(3'h0),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .irq(irq), .line_irq(line_irq),
    .line_event(line_event), .wakeup(wakeup)
  );

  gpio_irq_partner partner_u (
    .clock(clock), .line_event(line_event), .wakeup(wakeup),
    .gpio_pins(gpio_pins)
  );

  // ======
  // Bus and compare tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic aw;
    logic w;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    @(negedge clock);
    while (awvalid || wvalid)
    begin
      aw = awvalid && awready;
      w = wvalid && wready;
      @(posedge clock);
      if (aw)
        awvalid <= 1'b0;
      if (w)
        wvalid <= 1'b0;
      @(negedge clock);
    end
    while (!bvalid)
      @(negedge clock);
    chk({30'h0, bresp}, {30'h0, er});
    @(posedge clock);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(negedge clock);
    while (!arready)
      @(negedge clock);
    @(posedge clock);
    arvalid <= 1'b0;
    @(negedge clock);
    while (!rvalid)
      @(negedge clock);
    chk(rdata, ed);
    chk({30'h0, rresp}, {30'h0, er});
    @(posedge clock);
    rready <= 1'b0;
  endtask : rd

  // Waits a bounded time for one line to raise its interrupt.
  task automatic wait_line(input int ln);
    int i;
    for (i = 0; i < 20 && line_irq[ln] !== 1'b1; i++)
      @(negedge clock);
    chk({31'h0, line_irq[ln]}, 32'h1);
  endtask : wait_line

  // ======
  // Scenarios
  task automatic t_reset;
    for (int k = 0; k < 10; k++)
      if (k != 5)
        rd(8'(4 * k), eiec_pkg::RST_WORD, eiec_pkg::RESP_OKAY);
    rd(8'h14, 32'h0, eiec_pkg::RESP_SLVERR);
    wr(8'h14, 32'hffff_ffff, eiec_pkg::RESP_SLVERR);
    rd(8'h28, 32'h0, eiec_pkg::RESP_SLVERR);
  endtask : t_reset

  // Line 0 from pin 5, line 1 from pin 87, line 2 from pin 9.
  task automatic t_setup;
    wr(eiec_pkg::OFF_SRC0, 32'h0009_5705, eiec_pkg::RESP_OKAY);
    rd(eiec_pkg::OFF_SRC0, 32'h0009_5705, eiec_pkg::RESP_OKAY);
    wr(eiec_pkg::OFF_RISE_SEL, 32'h8000_0005, eiec_pkg::RESP_OKAY);
    wr(eiec_pkg::OFF_FALL_SEL, 32'h8000_0002, eiec_pkg::RESP_OKAY);
    wr(eiec_pkg::OFF_IRQ_MASK, 32'h0000_0003, eiec_pkg::RESP_OKAY);
    // Only the top byte lane is enabled, so the low bytes must not land.
    wstrb <= 4'h8;
    wr(eiec_pkg::OFF_EVENT_MASK, 32'h80ff_ffff, eiec_pkg::RESP_OKAY);
    wstrb <= 4'hf;
    rd(eiec_pkg::OFF_EVENT_MASK, 32'h8000_0000, eiec_pkg::RESP_OKAY);
  endtask : t_setup

  // A pulse much shorter than a clock period, placed between edges.
  task automatic t_short_rise;
    @(posedge clock);
    #30;
    partner_u.pulse(5, 20);
    wait_line(0);
    rd(eiec_pkg::OFF_PENDING, 32'h1, eiec_pkg::RESP_OKAY);
    @(negedge clock);
    chk({31'h0, irq}, 32'h1);
  endtask : t_short_rise

  task automatic t_fall_only;
    partner_u.set_pin(87, 1'b1);
    repeat (10) @(posedge clock);
    rd(eiec_pkg::OFF_PENDING, 32'h1, eiec_pkg::RESP_OKAY);
    partner_u.set_pin(87, 1'b0);
    wait_line(1);
    rd(eiec_pkg::OFF_PENDING, 32'h3, eiec_pkg::RESP_OKAY);
  endtask : t_fall_only

  // Line 2 is selected but masked, so nothing may leak out of it.
  task automatic t_masked;
    partner_u.pulse(9, 300);
    repeat (10) @(posedge clock);
    rd(eiec_pkg::OFF_PENDING, 32'h3, eiec_pkg::RESP_OKAY);
    @(negedge clock);
    chk(line_irq, 32'h3);
  endtask : t_masked

  task automatic t_clear;
    wr(eiec_pkg::OFF_PENDING, 32'h0, eiec_pkg::RESP_OKAY);
    rd(eiec_pkg::OFF_PENDING, 32'h3, eiec_pkg::RESP_OKAY);
    wr(eiec_pkg::OFF_PENDING, 32'h1, eiec_pkg::RESP_OKAY);
    rd(eiec_pkg::OFF_PENDING, 32'h2, eiec_pkg::RESP_OKAY);
    @(negedge clock);
    chk(line_irq, 32'h2);
    wr(eiec_pkg::OFF_PENDING, 32'h2, eiec_pkg::RESP_OKAY);
    repeat (2) @(negedge clock);
    chk({31'h0, irq}, 32'h0);
  endtask : t_clear

  // Internal line 31 on both edges, forwarded as events only.
  task automatic t_both_internal;
    int w0;
    // Earlier scenarios already raised wake-ups; count only this one's.
    w0 = partner_u.wake_count;
    @(posedge clock);
    internal_lines[15] <= 1'b1;
    repeat (10) @(posedge clock);
    internal_lines[15] <= 1'b0;
    repeat (10) @(negedge clock);
    chk(32'(partner_u.event_count[31]), 32'h2);
    chk(32'(partner_u.wake_count - w0), 32'h2);
    rd(eiec_pkg::OFF_PENDING, 32'h0, eiec_pkg::RESP_OKAY);
  endtask : t_both_internal

  task automatic summarize;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  // ======
  // Clock, reset, sequence and watchdog
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  initial
  begin
    rstn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata} = 48'h0;
    internal_lines = '0;
    wstrb = 4'hf;
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    repeat (2) @(posedge clock);
    t_reset();
    t_setup();
    t_short_rise();
    t_fall_only();
    t_masked();
    t_clear();
    t_both_internal();
    summarize();
  end

  // The whole sequence takes about two hundred cycles; the limit is 5000 cycles.
  initial
  begin
    #(5000 * 100);
    n_errors++;
    summarize();
  end
endmodule : test_edge_interrupt_event_controller
